// file: logic/dist_rec_pkg.sv
// Constants and types shared by the disturbance recorder control logic.
// Assumes a 50 MHz system clock and a synchronous active-low reset.
package dist_rec_pkg;

  // Clock and sample timing
  localparam int CLK_KHZ     = 50000;
  localparam int SAMPLE_MS   = 5;
  localparam int SAMPLE_CYC  = SAMPLE_MS * CLK_KHZ;
  localparam int SAMPLES_SEC = 1000 / SAMPLE_MS;

  // Recording limits
  localparam int MAX_RECS   = 100;
  localparam int MAX_LEN_MS = 1800000;
  localparam int MS_PER_SEC = 1000;
  localparam int STORE_CYC  = 8;

  // Binary channel set: external inputs, then built-in channels
  localparam int EXT_W      = 16;
  localparam int CH_W       = EXT_W + 6;
  localparam int CH_FALSE   = EXT_W;
  localparam int CH_TRUE    = EXT_W + 1;
  localparam int CH_PHASE   = EXT_W + 2;
  localparam int CH_FAULT   = EXT_W + 3;
  localparam int CH_SYNC    = EXT_W + 4;
  localparam int CH_PANEL   = EXT_W + 5;

  // Field widths
  localparam int CNT_W  = 7;
  localparam int MS_W   = 21;
  localparam int ID_W   = 16;
  localparam int TICK_W = 18;
  localparam int SMP_W  = 19;
  localparam int MATH_W = 48;

  // Reset values
  localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
  localparam logic [ID_W-1:0]  ID_ZERO  = 16'h0000;

  // Recorder status values
  typedef enum logic [2:0] {
    ST_READY,
    ST_TRIGGERED,
    ST_REC_STORE,
    ST_STORING,
    ST_FULL,
    ST_WRONG_CFG
  } rec_state_t;

endpackage

// file: logic/dist_rec_ctrl.sv
// Disturbance recorder control: channel sampling, triggering, record
// bookkeeping with clear commands, and capacity reporting.
// Assumes all inputs are synchronous to clk_i and settings are static
// while a recording runs; sample memory itself lives outside this block.
`timescale 1ns/10ps

// Summary of operation
// - sample binary channels once every 5 ms
// - start recording manually or by trigger inputs
// - any channel selectable; any selected active triggers
// - stored recordings never exceed 100
// - enable turns recorder on/off; disabled never starts
// - status is one of six values
// - clear index n deletes nth recording
// - manual trigger command starts a recording
// - manual trigger returns idle by itself
// - clear-all deletes everything, count zero; a store finishing in the same cycle still lands
// - clear-newest deletes most recent recording
// - clear-oldest deletes earliest recording
// - report max storable recordings, 0 to 100
// - size from channels, sample rate, recording time
// - report recordings held, 0 to 100
// - report max recording length, ms resolution
// - report largest permitted pre-trigger time
// - fault channel active on internal fault
// - sync alarm channel active when time lost
// - panel channel active while open/close pressed
module dist_rec_ctrl #(
  parameter int SAMPLE_CYCLES = dist_rec_pkg::SAMPLE_CYC,
  parameter int MEM_WORDS     = 4194304
) (
  // Clock and reset
  input  wire logic                                clk_i,
  input  wire logic                                reset_n_i,
  // Binary signal sources
  input  wire logic [dist_rec_pkg::EXT_W-1:0]      digital_input_n_i,
  input  wire logic                                phase_order_reversed_i,
  input  wire logic                                internal_fault_i,
  input  wire logic                                time_sync_lost_i,
  input  wire logic                                panel_open_btn_i,
  input  wire logic                                panel_close_btn_i,
  // Settings
  input  wire logic                                rec_enable_i,
  input  wire logic [dist_rec_pkg::CH_W-1:0]       trig_select_i,
  input  wire logic [7:0]                          analog_chans_i,
  input  wire logic [15:0]                         analog_rate_hz_i,
  input  wire logic [dist_rec_pkg::MS_W-1:0]       rec_time_ms_i,
  // Commands
  input  wire logic                                manual_trig_i,
  input  wire logic                                clear_all_i,
  input  wire logic                                clear_newest_i,
  input  wire logic                                clear_oldest_i,
  input  wire logic                                clear_index_we_i,
  input  wire logic [31:0]                         clear_index_i,
  // Status
  output logic                                     manual_trig_pending_o,
  output dist_rec_pkg::rec_state_t                 rec_status_o,
  output logic [dist_rec_pkg::CH_W-1:0]            chan_sample_o,
  output logic                                     sample_tick_o,
  output logic                                     record_stored_o,
  output logic [dist_rec_pkg::ID_W-1:0]            newest_id_o,
  output logic [dist_rec_pkg::CNT_W-1:0]           rec_count_o,
  output logic [dist_rec_pkg::CNT_W-1:0]           max_recs_o,
  output logic [dist_rec_pkg::MS_W-1:0]            max_len_ms_o,
  output logic [dist_rec_pkg::MS_W-1:0]            max_pretrig_ms_o
);

  typedef logic [dist_rec_pkg::MATH_W-1:0] wide_t;

  // Smaller of two wide values, used for every capped report
  function automatic wide_t min_w(input wide_t a, input wide_t b);
    min_w = (a < b) ? a : b;
  endfunction

  localparam wide_t W_MAX_RECS = wide_t'(dist_rec_pkg::MAX_RECS);
  localparam wide_t W_MAX_LEN  = wide_t'(dist_rec_pkg::MAX_LEN_MS);
  localparam wide_t W_MS_SEC   = wide_t'(dist_rec_pkg::MS_PER_SEC);
  localparam wide_t W_SMP_SEC  = wide_t'(dist_rec_pkg::SAMPLES_SEC);
  localparam wide_t W_CH       = wide_t'(dist_rec_pkg::CH_W);
  localparam wide_t W_MEM      = wide_t'(MEM_WORDS);
  localparam wide_t W_SMP_MS   = wide_t'(dist_rec_pkg::SAMPLE_MS);
  localparam logic [dist_rec_pkg::TICK_W-1:0] TICK_LAST =
    dist_rec_pkg::TICK_W'(SAMPLE_CYCLES - 1);
  localparam logic [3:0] STORE_LAST = 4'(dist_rec_pkg::STORE_CYC - 1);

  dist_rec_pkg::rec_state_t state;
  dist_rec_pkg::rec_state_t next_state;

  logic [dist_rec_pkg::TICK_W-1:0] tick_cnt;
  logic                            tick;
  logic [dist_rec_pkg::CH_W-1:0]   live_chans;
  logic                            trig_hit;
  logic                            start_rec;
  logic [dist_rec_pkg::SMP_W-1:0]  smp_cnt;
  logic [dist_rec_pkg::SMP_W-1:0]  rec_samples;
  logic [3:0]                      store_cnt;
  logic                            store_done;
  logic                            cfg_bad;
  logic                            is_full;
  wide_t                           words_sec;
  wide_t                           rec_words;
  wide_t                           cap_recs;
  wide_t                           cap_len;

  // Record table: one tag per stored recording, oldest at slot 0
  logic [dist_rec_pkg::ID_W-1:0] rec_id [dist_rec_pkg::MAX_RECS];
  logic [dist_rec_pkg::ID_W-1:0] next_rec_id [dist_rec_pkg::MAX_RECS];
  logic [dist_rec_pkg::CNT_W-1:0] next_count;
  logic [dist_rec_pkg::ID_W-1:0]  id_seq;

  // Channel set assembly; built-ins sit above the external inputs
  always_comb begin
    live_chans = {dist_rec_pkg::CH_W{1'b0}};
    live_chans[dist_rec_pkg::EXT_W-1:0] = digital_input_n_i;
    live_chans[dist_rec_pkg::CH_FALSE]  = 1'b0;
    live_chans[dist_rec_pkg::CH_TRUE]   = 1'b1;
    live_chans[dist_rec_pkg::CH_PHASE]  = phase_order_reversed_i;
    live_chans[dist_rec_pkg::CH_FAULT]  = internal_fault_i;
    live_chans[dist_rec_pkg::CH_SYNC]   = time_sync_lost_i;
    live_chans[dist_rec_pkg::CH_PANEL]  = panel_open_btn_i | panel_close_btn_i;
  end

  // Sample period counter; it idles while disabled so a restart
  // begins a full period, not a partial one
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !rec_enable_i) begin
      tick_cnt <= '0;
    end else if (tick_cnt == TICK_LAST) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end

  assign tick = rec_enable_i && (tick_cnt == TICK_LAST);

  // Channel snapshot taken once per period
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      chan_sample_o <= '0;
      sample_tick_o <= 1'b0;
    end else begin
      sample_tick_o <= tick;
      if (tick) begin
        chan_sample_o <= live_chans;
      end
    end
  end

  // Record size and capacity arithmetic
  always_comb begin
    words_sec = wide_t'(analog_chans_i) * wide_t'(analog_rate_hz_i)
              + W_CH * W_SMP_SEC;
    rec_words = words_sec * wide_t'(rec_time_ms_i) / W_MS_SEC;
    cap_recs  = (rec_words == '0) ? '0 : min_w(W_MEM / rec_words, W_MAX_RECS);
    cap_len   = min_w(W_MEM * W_MS_SEC / words_sec, W_MAX_LEN);
    cfg_bad   = (rec_time_ms_i == '0) || (cap_recs == '0)
              || (wide_t'(rec_time_ms_i) > cap_len);
    rec_samples = dist_rec_pkg::SMP_W'(wide_t'(rec_time_ms_i) / W_SMP_MS);
  end

  // Capacity reports come from flops so they do not glitch
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      max_recs_o       <= dist_rec_pkg::CNT_ZERO;
      max_len_ms_o     <= '0;
      max_pretrig_ms_o <= '0;
    end else begin
      max_recs_o       <= dist_rec_pkg::CNT_W'(cap_recs);
      max_len_ms_o     <= dist_rec_pkg::MS_W'(cap_len);
      max_pretrig_ms_o <= dist_rec_pkg::MS_W'(min_w(cap_len,
                            wide_t'(rec_time_ms_i)));
    end
  end

  // Full looks at the count after this cycle's clears and store, so the
  // status turns full on the same edge that takes the last free slot
  assign is_full = (next_count >= max_recs_o) ||
                   (next_count == dist_rec_pkg::CNT_W'(dist_rec_pkg::MAX_RECS));

  // Trigger decision: only in ready, only on a sample edge
  assign trig_hit  = |(trig_select_i & live_chans);
  assign start_rec = (state == dist_rec_pkg::ST_READY) && tick
                     && (manual_trig_pending_o || trig_hit);
  assign store_done = (state == dist_rec_pkg::ST_STORING) && (store_cnt == STORE_LAST);

  // Manual command is held until acted on or until the recorder is disabled, then falls back to idle;
  // a new command in the same cycle as the start is kept
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      manual_trig_pending_o <= 1'b0;
    end else if (manual_trig_i && rec_enable_i) begin
      manual_trig_pending_o <= 1'b1;
    end else if (start_rec || !rec_enable_i) begin
      manual_trig_pending_o <= 1'b0;
    end
  end

  // Status machine
  always_comb begin
    next_state = state;
    case (state)
      dist_rec_pkg::ST_READY: begin
        if (start_rec) begin
          next_state = dist_rec_pkg::ST_TRIGGERED;
        end
      end
      dist_rec_pkg::ST_TRIGGERED: begin
        if (tick) begin
          next_state = dist_rec_pkg::ST_REC_STORE;
        end
      end
      dist_rec_pkg::ST_REC_STORE: begin
        if (tick && (smp_cnt >= rec_samples)) begin
          next_state = dist_rec_pkg::ST_STORING;
        end
      end
      dist_rec_pkg::ST_STORING: begin
        if (store_done) begin
          next_state = dist_rec_pkg::ST_READY;
        end
      end
      dist_rec_pkg::ST_FULL,
      dist_rec_pkg::ST_WRONG_CFG: begin
        next_state = dist_rec_pkg::ST_READY;
      end
      default: begin
        next_state = dist_rec_pkg::ST_READY;
      end
    endcase
    // Idle states re-evaluate every cycle; a running capture finishes unless enable drops, which forces ready
    if (next_state == dist_rec_pkg::ST_READY) begin
      if (cfg_bad) begin
        next_state = dist_rec_pkg::ST_WRONG_CFG;
      end else if (is_full) begin
        next_state = dist_rec_pkg::ST_FULL;
      end
    end
    if (!rec_enable_i) begin
      next_state = dist_rec_pkg::ST_READY;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state <= dist_rec_pkg::ST_READY;
    end else begin
      state <= next_state;
    end
  end

  assign rec_status_o = state;

  // Sample and store-phase counters
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || state == dist_rec_pkg::ST_READY) begin
      smp_cnt   <= '0;
      store_cnt <= '0;
    end else begin
      if (state == dist_rec_pkg::ST_REC_STORE && tick) begin
        smp_cnt <= smp_cnt + 1'b1;
      end
      if (state == dist_rec_pkg::ST_STORING) begin
        store_cnt <= store_cnt + 1'b1;
      end
    end
  end

  // Table update: clears apply first, then a finished record is
  // appended, so a clear and a store in one cycle are both honoured
  always_comb begin
    logic [dist_rec_pkg::CNT_W-1:0] cnt;
    logic [31:0]                    del;
    logic                           do_del;
    cnt    = rec_count_o;
    del    = '0;
    do_del = 1'b0;
    for (int i = 0; i < dist_rec_pkg::MAX_RECS; i++) begin
      next_rec_id[i] = rec_id[i];
    end
    if (clear_all_i) begin
      cnt = dist_rec_pkg::CNT_ZERO;
    end else if (clear_newest_i && cnt != '0) begin
      cnt = cnt - 1'b1;
    end else if (clear_oldest_i && cnt != '0) begin
      do_del = 1'b1;
    end else if (clear_index_we_i && clear_index_i != '0
                 && clear_index_i <= 32'(cnt)) begin
      do_del = 1'b1;
      del    = clear_index_i - 1'b1;
    end
    if (do_del) begin
      for (int i = 0; i < dist_rec_pkg::MAX_RECS - 1; i++) begin
        if (32'(i) >= del) begin
          next_rec_id[i] = rec_id[i + 1];
        end
      end
      cnt = cnt - 1'b1;
    end
    if (store_done && cnt < max_recs_o
        && cnt < dist_rec_pkg::CNT_W'(dist_rec_pkg::MAX_RECS)) begin
      next_rec_id[cnt] = id_seq;
      cnt = cnt + 1'b1;
    end
    next_count = cnt;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rec_count_o <= dist_rec_pkg::CNT_ZERO;
      for (int i = 0; i < dist_rec_pkg::MAX_RECS; i++) begin
        rec_id[i] <= dist_rec_pkg::ID_ZERO;
      end
    end else begin
      rec_count_o <= next_count;
      for (int i = 0; i < dist_rec_pkg::MAX_RECS; i++) begin
        rec_id[i] <= next_rec_id[i];
      end
    end
  end

  // Running tag for each recording; the newest tag is reported
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      id_seq          <= dist_rec_pkg::ID_ZERO;
      newest_id_o     <= dist_rec_pkg::ID_ZERO;
      record_stored_o <= 1'b0;
    end else begin
      record_stored_o <= store_done;
      newest_id_o     <= (next_count == '0) ? dist_rec_pkg::ID_ZERO
                         : next_rec_id[next_count - 1'b1];
      if (store_done) begin
        id_seq <= id_seq + 1'b1;
      end
    end
  end

endmodule

// file: dv/dist_rec_sources.sv
// Model of the binary signal sources that feed the recorder.
// Assumes the bench sets wanted levels; they show one edge later.
`timescale 1ns/10ps
module dist_rec_sources (
  // Clock and wanted levels
  input  wire logic        clk_i,
  input  wire logic [20:0] level_i,
  // Source levels
  output logic [15:0]      digital_input_n_o,
  output logic             phase_order_reversed_o,
  output logic             internal_fault_o,
  output logic             time_sync_lost_o,
  output logic             panel_open_btn_o,
  output logic             panel_close_btn_o
);
  // Quiet sources at time zero, before the first edge
  initial begin
    {panel_close_btn_o, panel_open_btn_o, time_sync_lost_o} = 3'h0;
    {internal_fault_o, phase_order_reversed_o, digital_input_n_o} = 18'h0;
  end

  // Real sources are registered in their own logic, so levels move after an edge
  always @(posedge clk_i) begin
    {panel_close_btn_o, panel_open_btn_o, time_sync_lost_o} <= level_i[20:18];
    {internal_fault_o, phase_order_reversed_o, digital_input_n_o} <= level_i[17:0];
  end
endmodule

// file: dv/dist_rec_ctrl_checker.sv
// Port assertions for the recorder control block.
// Assumes settings stay still while records are made.
`timescale 1ns/10ps
module dist_rec_ctrl_checker #(
  parameter int SAMPLE_CYCLES = 20
) (
  // Clock, reset, settings and commands
  input wire logic                     clk_i,
  input wire logic                     reset_n_i,
  input wire logic                     rec_enable_i,
  input wire logic                     manual_trig_i,
  input wire logic                     clear_all_i,
  input wire logic                     clear_newest_i,
  input wire logic                     clear_oldest_i,
  input wire logic                     clear_index_we_i,
  input wire logic [31:0]              clear_index_i,
  // Design outputs
  input wire logic                     manual_trig_pending_o,
  input wire dist_rec_pkg::rec_state_t rec_status_o,
  input wire logic [21:0]              chan_sample_o,
  input wire logic                     sample_tick_o,
  input wire logic [6:0]               rec_count_o,
  input wire logic [6:0]               max_recs_o
);
  localparam int PEND_MAX = SAMPLE_CYCLES + 1;
  logic [31:0] gap;
  logic        seen;
  logic        quiet;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // A store landing in the same cycle as a clear adds one back, so skip it
  assign quiet = rec_status_o != dist_rec_pkg::ST_STORING;

  // Cycles since the last tick; the design restarts its count when disabled
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !rec_enable_i) begin
      gap  <= 32'h0;
      seen <= 1'b0;
    end else begin
      gap  <= sample_tick_o ? 32'h0 : gap + 32'h1;
      seen <= seen | sample_tick_o;
    end
  end

  // Steps of the tick pulse and of the manual command
  sequence s_tick_drop;
    ##1 !sample_tick_o;
  endsequence
  sequence s_pend_gone;
    ##[1:PEND_MAX] !manual_trig_pending_o;
  endsequence

  chk_tick_period: assert property (sample_tick_o && seen |-> gap == SAMPLE_CYCLES - 1)
    else $error("sample ticks not one period apart");
  chk_tick_pulse: assert property (sample_tick_o |-> s_tick_drop)
    else $error("sample tick longer than one cycle");
  chk_const_chans: assert property (sample_tick_o |-> !chan_sample_o[16] && chan_sample_o[17])
    else $error("constant channels wrong");
  chk_status_legal: assert property (rec_status_o <= dist_rec_pkg::ST_WRONG_CFG)
    else $error("status outside the six values");
  chk_count_cap: assert property (rec_count_o <= 7'h64 && max_recs_o <= 7'h64)
    else $error("count above one hundred");
  chk_pend_clear: assert property (manual_trig_pending_o && rec_enable_i && !manual_trig_i &&
    rec_status_o == dist_rec_pkg::ST_READY |-> s_pend_gone) else $error("manual command not returned to idle");
  chk_clear_all: assert property (clear_all_i && quiet |=> rec_count_o == 7'h00)
    else $error("clear all left records");
  chk_clear_newest: assert property (clear_newest_i && !clear_all_i && rec_count_o != 7'h00 && quiet
    |=> rec_count_o == $past(rec_count_o) - 7'h01) else $error("clear newest count wrong");
  chk_bad_index: assert property (clear_index_we_i && !clear_all_i && !clear_newest_i && !clear_oldest_i
    && quiet && (clear_index_i == 0 || clear_index_i > rec_count_o) |=> $stable(rec_count_o))
    else $error("bad clear index changed count");
  chk_ready_room: assert property ($past(reset_n_i) && rec_status_o == dist_rec_pkg::ST_READY
    |-> rec_count_o < max_recs_o) else $error("ready while store full");
  chk_off_idle: assert property (!rec_enable_i && rec_status_o == dist_rec_pkg::ST_READY
    |=> rec_status_o != dist_rec_pkg::ST_TRIGGERED) else $error("recording started while disabled");
endmodule

bind dist_rec_ctrl dist_rec_ctrl_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) chk_i (.clk_i, .reset_n_i,
  .rec_enable_i, .manual_trig_i, .clear_all_i, .clear_newest_i, .clear_oldest_i, .clear_index_we_i,
  .clear_index_i, .manual_trig_pending_o, .rec_status_o, .chan_sample_o, .sample_tick_o, .rec_count_o,
  .max_recs_o);

// file: dv/disturbance_recorder_control_test.sv
// Self-checking bench for the recorder control block.
// Assumes a short sample period and a memory that holds three records.
`timescale 1ns/10ps
module disturbance_recorder_control_test;
  localparam int SC = 20;
  logic        clk_i, reset_n_i, rec_enable_i, sample_tick_o, record_stored_o;
  logic        manual_trig_pending_o, phase, fault, sync, open_b, close_b;
  logic [4:0]  cmd;
  logic [7:0]  ach;
  logic [6:0]  rec_count_o, max_recs_o;
  logic [15:0] dig, newest_id_o, arate;
  logic [20:0] lvl, max_len_ms_o, max_pretrig_ms_o, rtime;
  logic [21:0] trig_select_i, chan_sample_o;
  logic [31:0] clear_index_i;
  dist_rec_pkg::rec_state_t rec_status_o;
  int          fails = 0;
  int          n_checks = 0;

  dist_rec_sources src (.clk_i, .level_i(lvl), .digital_input_n_o(dig), .phase_order_reversed_o(phase),
    .internal_fault_o(fault), .time_sync_lost_o(sync), .panel_open_btn_o(open_b), .panel_close_btn_o(close_b));
  // Tiny memory: 4400 words/s at 10 ms gives 44 words, so three records fit
  dist_rec_ctrl #(.SAMPLE_CYCLES(SC), .MEM_WORDS(132)) uut (.clk_i, .reset_n_i, .digital_input_n_i(dig),
    .phase_order_reversed_i(phase), .internal_fault_i(fault), .time_sync_lost_i(sync),
    .panel_open_btn_i(open_b), .panel_close_btn_i(close_b), .rec_enable_i, .trig_select_i,
    .analog_chans_i(ach), .analog_rate_hz_i(arate), .rec_time_ms_i(rtime), .manual_trig_i(cmd[0]),
    .clear_all_i(cmd[1]), .clear_newest_i(cmd[2]), .clear_oldest_i(cmd[3]), .clear_index_we_i(cmd[4]),
    .clear_index_i, .manual_trig_pending_o, .rec_status_o, .chan_sample_o, .sample_tick_o, .record_stored_o,
    .newest_id_o, .rec_count_o, .max_recs_o, .max_len_ms_o, .max_pretrig_ms_o);

  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic complete_run;
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bounded wait for a tick or a stored pulse; a hang ends the run
  task automatic wait_on(input bit stored);
    int i;
    for (i = 0; i < 300; i++) begin
      @(negedge clk_i);
      if ((stored ? record_stored_o : sample_tick_o) === 1'b1) break;
    end
    if (i == 300) begin
      fails++;
      complete_run();
    end
  endtask

  task automatic pulse(input logic [4:0] c, input logic [31:0] n);
    @(posedge clk_i) begin
      cmd           <= c;
      clear_index_i <= n;
    end
    @(posedge clk_i) cmd <= 5'h00;
    @(negedge clk_i);
  endtask

  task automatic t_capacity;
    chk("max_recs", 32'h3, 32'(max_recs_o));
    chk("max_len", 32'h1e, 32'(max_len_ms_o));
    chk("max_pretrig", 32'ha, 32'(max_pretrig_ms_o));
    chk("status", dist_rec_pkg::ST_READY, 32'(rec_status_o));
  endtask

  // Extra analog load shrinks capacity; a zero time is a wrong configuration
  task automatic t_config;
    @(posedge clk_i) begin
      ach   <= 8'h02;
      arate <= 16'h00c8;
    end
    repeat (3) @(negedge clk_i);
    chk("max_recs", 32'h2, 32'(max_recs_o));
    chk("max_len", 32'h1b, 32'(max_len_ms_o));
    @(posedge clk_i) rtime <= 21'h000000;
    repeat (3) @(negedge clk_i);
    chk("status", dist_rec_pkg::ST_WRONG_CFG, 32'(rec_status_o));
    chk("max_recs", 32'h0, 32'(max_recs_o));
    chk("max_pretrig", 32'h0, 32'(max_pretrig_ms_o));
    @(posedge clk_i) begin
      ach   <= 8'h00;
      arate <= 16'h0000;
      rtime <= 21'h00000a;
    end
    repeat (3) @(negedge clk_i);
    chk("status", dist_rec_pkg::ST_READY, 32'(rec_status_o));
  endtask

  // Second tick is sure to see the new levels
  task automatic t_sample(input logic [20:0] l, input logic [31:0] exp);
    @(posedge clk_i) lvl <= l;
    wait_on(0);
    wait_on(0);
    chk("chan_sample", exp, 32'(chan_sample_o));
  endtask

  // Command given just after a tick so the pending flag is seen first
  task automatic rec_manual(input logic [6:0] n, input logic [15:0] id);
    wait_on(0);
    pulse(5'h01, 32'h0);
    chk("pending", 32'h1, 32'(manual_trig_pending_o));
    wait_on(0);
    chk("pending", 32'h0, 32'(manual_trig_pending_o));
    chk("status", dist_rec_pkg::ST_TRIGGERED, 32'(rec_status_o));
    wait_on(1);
    chk("count", 32'(n), 32'(rec_count_o));
    chk("newest_id", 32'(id), 32'(newest_id_o));
  endtask

  task automatic t_disabled;
    @(posedge clk_i) rec_enable_i <= 1'b0;
    pulse(5'h01, 32'h0);
    repeat (3 * SC) @(negedge clk_i);
    chk("count", 32'h0, 32'(rec_count_o));
    chk("pending", 32'h0, 32'(manual_trig_pending_o));
    chk("status", dist_rec_pkg::ST_READY, 32'(rec_status_o));
    @(posedge clk_i) rec_enable_i <= 1'b1;
  endtask

  // Constant-0 channel selected must never fire; constant-1 must
  task automatic t_select;
    @(posedge clk_i) trig_select_i <= 22'h010000;
    repeat (3 * SC) @(negedge clk_i);
    chk("count", 32'h1, 32'(rec_count_o));
    @(posedge clk_i) trig_select_i <= 22'h020000;
    wait_on(1);
    chk("count", 32'h2, 32'(rec_count_o));
    @(posedge clk_i) trig_select_i <= 22'h000000;
  endtask

  task automatic t_full;
    chk("status", dist_rec_pkg::ST_FULL, 32'(rec_status_o));
    @(posedge clk_i) trig_select_i <= 22'h020000;
    repeat (4 * SC) @(negedge clk_i);
    chk("count", 32'h3, 32'(rec_count_o));
    chk("status", dist_rec_pkg::ST_FULL, 32'(rec_status_o));
    @(posedge clk_i) trig_select_i <= 22'h000000;
  endtask

  task automatic t_clears;
    pulse(5'h04, 32'h0);
    chk("count", 32'h2, 32'(rec_count_o));
    chk("newest_id", 32'h1, 32'(newest_id_o));
    pulse(5'h10, 32'h0);
    pulse(5'h10, 32'h3);
    chk("count", 32'h2, 32'(rec_count_o));
    pulse(5'h10, 32'h1);
    chk("count", 32'h1, 32'(rec_count_o));
    chk("newest_id", 32'h1, 32'(newest_id_o));
    rec_manual(7'h02, 16'h0003);
    pulse(5'h08, 32'h0);
    chk("count", 32'h1, 32'(rec_count_o));
    chk("newest_id", 32'h3, 32'(newest_id_o));
    rec_manual(7'h02, 16'h0004);
    pulse(5'h02, 32'h0);
    chk("count", 32'h0, 32'(rec_count_o));
  endtask

  // Main sequence
  initial begin
    reset_n_i     = 1'b0;
    rec_enable_i  = 1'b1;
    cmd           = 5'h00;
    clear_index_i = 32'h0;
    trig_select_i = 22'h0;
    lvl           = 21'h0;
    ach           = 8'h00;
    arate         = 16'h0000;
    rtime         = 21'h00000a;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(negedge clk_i);
    t_capacity();
    t_config();
    t_sample(21'h13a5c3, 32'h002ea5c3);
    t_sample(21'h0c5a3c, 32'h00325a3c);
    t_disabled();
    rec_manual(7'h01, 16'h0000);
    t_select();
    rec_manual(7'h03, 16'h0002);
    t_full();
    t_clears();
    complete_run();
  end
endmodule
